// ---- hdl/tpc_defs.vh ----
// constants for the transmit per-channel indirect access block
`ifndef TPC_DEFS_VH
`define TPC_DEFS_VH
// register word indices, compared against i_wb_adr[9:2] (byte address = index * 4)
`define TPC_IDX_CONFIG 8'h6C
`define TPC_IDX_STATUS 8'h6D
`define TPC_IDX_ADDR_CTRL 8'h6E
`define TPC_IDX_DATA 8'h6F
`define TPC_ADR_W 10
// config fields
`define TPC_CFG_ENABLE_BIT 0
`define TPC_CFG_INDIRECT_BIT 1
`define TPC_CFG_RESERVED_BIT 2
`define TPC_CFG_RESET 3'h0
// status / addr-ctrl fields
`define TPC_STAT_BUSY_BIT 7
`define TPC_AC_RNW_BIT 7
`define TPC_AC_RESET 8'h00
`define TPC_DATA_RESET 8'h00
// bank layout
`define TPC_BANK_PCM_BASE 7'h20
`define TPC_BANK_PCM_LAST 7'h3F
`define TPC_BANK_IDLE_BASE 7'h40
`define TPC_BANK_SIG_BASE 7'h60
`define TPC_BANK_FIRST 7'h20
`define TPC_BANK_LAST 7'h7F
`define TPC_BANK_DEPTH 96
`define TPC_BANK_AW 7
// timing: 640 ns budget, 100 MHz clock
`define TPC_ACCESS_NS 640
`define TPC_CLK_NS 10
`define TPC_ACCESS_CYC (`TPC_ACCESS_NS / `TPC_CLK_NS)
// high-speed access tick: one enable every 4 clocks
`define TPC_TICK_DIV 4
`define TPC_ACCESS_TICKS 4
// last count of each, sized to the counters that compare against them
`define TPC_TICK_LAST 2'h3
`define TPC_ACCESS_LAST 3'h3
`endif

// ---- hdl/tpc_tick.v ----
// divider producing the internal high-speed access enable pulse
`timescale 1ns/100ps
`include "tpc_defs.vh"
module tpc_tick (
  input wire i_clock,
  input wire i_sys_rst,
  output reg o_tick
);
  reg [1:0] count;
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count <= 2'h0;
      o_tick <= 1'b0;
    end else begin
      count <= count + 2'h1;
      o_tick <= (count == `TPC_TICK_LAST);
    end
  end
endmodule

// ---- hdl/tpc_bank.v ----
// internal per-timeslot byte bank: pcm control, idle code, signaling
`timescale 1ns/100ps
`include "tpc_defs.vh"
module tpc_bank (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_we,
  input wire [6:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  input wire [4:0] i_slot,
  output reg [7:0] o_pcm,
  output reg [7:0] o_idle,
  output reg [7:0] o_sig
);
  reg [7:0] mem [0:`TPC_BANK_DEPTH-1];
  wire [6:0] offs;
  assign offs = i_addr - `TPC_BANK_FIRST;
  integer k;
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
      o_pcm <= 8'h00;
      o_idle <= 8'h00;
      o_sig <= 8'h00;
      for (k = 0; k < `TPC_BANK_DEPTH; k = k + 1) begin
        mem[k] <= 8'h00;
      end
    end else begin
      if (i_we && i_addr >= `TPC_BANK_FIRST) begin
        mem[offs] <= i_wdata;
      end
      // reserved low indices read as zero
      if (i_addr >= `TPC_BANK_FIRST) begin
        o_rdata <= mem[offs];
      end else begin
        o_rdata <= 8'h00;
      end
      o_pcm <= mem[{2'h0, i_slot}];
      o_idle <= mem[{2'h1, i_slot}];
      o_sig <= mem[{2'h2, i_slot}];
    end
  end
endmodule

// ---- hdl/tpc_access.v ----
// transmit per-channel controller: wishbone registers and indirect access
//
// How it works
// - indirect select must be set by software
// - indirect select clears on reset
// - enable passes channel bytes to framer
// - busy high during access, falls on tick
// - access finishes within 640 ns
// - address/control write starts internal access
// - select one reads, zero writes
// - data buffer holds write byte, read result
// - read result ready in data buffer
// - pcm control at 20H plus timeslot
// - bank holds pcm, idle, signaling bytes
// - pcm bytes run to 3FH, 32 slots
// - idle code at 40H plus timeslot
// - e1/signaling control bytes from 60H
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
`include "tpc_defs.vh"
module tpc_access (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [`TPC_ADR_W-1:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire [4:0] i_slot,
  output reg o_framer_valid,
  output reg [7:0] o_framer_pcm,
  output reg [7:0] o_framer_idle,
  output reg [7:0] o_framer_sig
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_LAND = 2'h2;
  localparam ST_DONE = 2'h3;

  reg [2:0] cfg;
  reg [7:0] addr_ctrl;
  reg [7:0] data_buf;
  reg busy;
  reg [1:0] state;
  reg [2:0] ticks;
  reg bank_we;
  wire tick;
  wire [7:0] bank_rdata;
  wire [7:0] pcm;
  wire [7:0] idle;
  wire [7:0] sig;

  tpc_tick tpc_tick_inst (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .o_tick(tick)
  );

  tpc_bank tpc_bank_inst (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_we(bank_we),
    .i_addr(addr_ctrl[6:0]),
    .i_wdata(data_buf),
    .o_rdata(bank_rdata),
    .i_slot(i_slot),
    .o_pcm(pcm),
    .o_idle(idle),
    .o_sig(sig)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req;
  wire [7:0] idx;
  wire wr;
  wire lane0;
  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign idx = i_wb_adr[`TPC_ADR_W-1:2];
  assign lane0 = i_wb_sel[0];
  assign wr = req & i_wb_we & lane0;
  wire hit_cfg;
  wire hit_ac;
  wire hit_data;
  assign hit_cfg = (idx == `TPC_IDX_CONFIG);
  assign hit_ac = (idx == `TPC_IDX_ADDR_CTRL);
  assign hit_data = (idx == `TPC_IDX_DATA);
  // starts only when indirect mode is on and bank idle
  wire start;
  assign start = wr & hit_ac & cfg[`TPC_CFG_INDIRECT_BIT] & ~busy;

  reg [7:0] next_rd;
  always @* begin
    next_rd = 8'h00;
    case (idx)
      `TPC_IDX_CONFIG: next_rd = {5'h00, cfg};
      `TPC_IDX_STATUS: next_rd = {busy, 7'h00};
      `TPC_IDX_ADDR_CTRL: next_rd = addr_ctrl;
      `TPC_IDX_DATA: next_rd = data_buf;
      default: next_rd = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // registers and bus answer
  // ----------------------------------------------------------------
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      cfg <= `TPC_CFG_RESET;
      addr_ctrl <= `TPC_AC_RESET;
    end else begin
      o_wb_ack <= req;
      if (req && !i_wb_we) begin
        o_wb_dat <= {24'h000000, next_rd};
      end
      if (wr && hit_cfg) begin
        // reserved bit stored as written; logic ignores it
        cfg <= i_wb_dat[2:0];
      end
      // writes while busy are dropped so the running access is safe
      if (start) begin
        addr_ctrl <= i_wb_dat[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // indirect access sequencer
  // ----------------------------------------------------------------
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      ticks <= 3'h0;
      bank_we <= 1'b0;
      data_buf <= `TPC_DATA_RESET;
    end else begin
      bank_we <= 1'b0;
      if (wr && hit_data && !busy) begin
        data_buf <= i_wb_dat[7:0];
      end
      case (state)
        ST_IDLE: begin
          if (start) begin
            busy <= 1'b1;
            ticks <= 3'h0;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          // 4 ticks of 4 clocks: well inside the 640 ns budget
          if (tick) begin
            ticks <= ticks + 3'h1;
            if (ticks == `TPC_ACCESS_LAST) begin
              state <= ST_LAND;
              bank_we <= ~addr_ctrl[`TPC_AC_RNW_BIT];
            end
          end
        end
        ST_LAND: begin
          // bank read data is registered; wait one cycle for it
          state <= ST_DONE;
        end
        ST_DONE: begin
          if (addr_ctrl[`TPC_AC_RNW_BIT]) begin
            data_buf <= bank_rdata;
          end
          if (tick) begin
            busy <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // framer feed
  // ----------------------------------------------------------------
  // slot bytes come from 20H/40H/60H plus slot, 32 slots each
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_framer_valid <= 1'b0;
      o_framer_pcm <= 8'h00;
      o_framer_idle <= 8'h00;
      o_framer_sig <= 8'h00;
    end else begin
      o_framer_valid <= cfg[`TPC_CFG_ENABLE_BIT];
      if (cfg[`TPC_CFG_ENABLE_BIT]) begin
        o_framer_pcm <= pcm;
        o_framer_idle <= idle;
        o_framer_sig <= sig;
      end else begin
        o_framer_pcm <= 8'h00;
        o_framer_idle <= 8'h00;
        o_framer_sig <= 8'h00;
      end
    end
  end
endmodule

// ---- verif/tpc_access_sva.sv ----
// assertions on the ports of the transmit per-channel access block
`timescale 1ns/100ps
`include "tpc_defs.vh"
module tpc_access_sva (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [`TPC_ADR_W-1:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  input wire [4:0] i_slot,
  input wire o_framer_valid,
  input wire [7:0] o_framer_pcm,
  input wire [7:0] o_framer_idle,
  input wire [7:0] o_framer_sig
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire cfg_wr = req && i_wb_we && i_wb_adr == 10'h1B0 && i_wb_sel[0];
  chk_ack_follows: assert property (req |=> o_wb_ack)
    else $error("request not acknowledged");
  chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_dat_upper: assert property (
    o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_enable_on: assert property (
    cfg_wr && i_wb_dat[0] |-> ##[1:3] o_framer_valid)
    else $error("enable did not reach framer");
  chk_enable_off: assert property (
    cfg_wr && !i_wb_dat[0] |-> ##[1:3] !o_framer_valid)
    else $error("disable did not reach framer");
  // three cycles of margin for the output register latency
  chk_pcm_off: assert property (
    !o_framer_valid [*3] |-> o_framer_pcm == 8'h00)
    else $error("pcm byte while disabled");
  chk_idle_off: assert property (
    !o_framer_valid [*3] |-> o_framer_idle == 8'h00)
    else $error("idle byte while disabled");
  chk_sig_off: assert property (
    !o_framer_valid [*3] |-> o_framer_sig == 8'h00)
    else $error("sig byte while disabled");
  cover property (cfg_wr && i_wb_dat[0]);
  cover property (o_framer_valid && o_framer_pcm != 8'h00);
  cover property (req && !i_wb_we && i_wb_adr == 10'h1BC);
endmodule
bind tpc_access tpc_access_sva tpc_access_sva_inst (.i_clock, .i_sys_rst,
  .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
  .o_wb_dat, .o_wb_ack, .i_slot, .o_framer_valid, .o_framer_pcm,
  .o_framer_idle, .o_framer_sig);

// ---- verif/tpc_access_tb.sv ----
// self-checking bench for the transmit per-channel access block
`timescale 1ns/100ps
module tpc_access_tb;
  logic i_clock = 0, i_sys_rst = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
  logic [9:0] i_wb_adr = 10'h000;
  logic [3:0] i_wb_sel = 4'hF;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
  logic [4:0] i_slot = 5'h00;
  logic o_wb_ack, o_framer_valid;
  logic [7:0] o_framer_pcm, o_framer_idle, o_framer_sig, rd;
  logic [22:0] rows [7];
  int n_errors = 0, num_checks = 0, ticks = 0, i;
  time t;
  tpc_access tpc_access_inst (.i_clock, .i_sys_rst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
    .i_slot, .o_framer_valid, .o_framer_pcm, .o_framer_idle,
    .o_framer_sig);
  always #5 i_clock = ~i_clock;
  task summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge i_clock) begin
    ticks++;
    if (ticks == 20000) begin
      n_errors++;
      summarize;
    end
  end
  task chk(input [31:0] s, input [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wb(input w, input [9:0] a, input [7:0] d);
    @(posedge i_clock);
    i_wb_cyc <= 1;
    i_wb_stb <= 1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= {24'h0, d};
    do @(posedge i_clock); while (o_wb_ack !== 1'b1);
    rd = o_wb_dat[7:0];
    i_wb_cyc <= 0;
    i_wb_stb <= 0;
  endtask
  // access start is taken at the ack of the address/control write
  task poll;
    do wb(0, 10'h1B4, 8'h00); while (rd[7] !== 1'b0);
    chk($time - t <= 640, 1);
  endtask
  task acc(input [7:0] ac);
    wb(1, 10'h1B8, ac);
    t = $time;
    poll;
  endtask
  // all four registers at their reset values, busy low
  task check_defaults;
    for (i = 0; i < 4; i++) begin
      wb(0, 10'(10'h1B0 + 4 * i), 8'h00);
      chk(rd & (i == 0 ? 8'h07 : i == 1 ? 8'h80 : 8'hFF), 0);
    end
  endtask
  initial begin
    // a real rising edge, so the asynchronous reset is seen at all
    i_sys_rst <= 1'b1;
    rows = '{{7'h20, 8'hA5, 8'hA5}, {7'h3F, 8'h3C, 8'h3C},
      {7'h40, 8'h96, 8'h96}, {7'h5F, 8'hC3, 8'hC3}, {7'h60, 8'h69, 8'h69},
      {7'h7F, 8'h7E, 8'h7E}, {7'h10, 8'h5A, 8'h00}};
    repeat (12) @(posedge i_clock);
    i_sys_rst <= 0;
    check_defaults;
    wb(1, 10'h1B8, 8'h20);
    wb(0, 10'h1B8, 8'h00);
    chk(rd, 0);
    wb(1, 10'h1B0, 8'h03);
    wb(0, 10'h1B0, 8'h00);
    chk(rd & 8'h07, 3);
    foreach (rows[k]) begin
      wb(1, 10'h1BC, rows[k][15:8]);
      acc({1'b0, rows[k][22:16]});
    end
    foreach (rows[k]) begin
      acc({1'b1, rows[k][22:16]});
      wb(0, 10'h1BC, 8'h00);
      chk(rd, rows[k][7:0]);
    end
    // a buffer write during busy must not clobber the fetched byte
    wb(1, 10'h1B8, 8'hA0);
    t = $time;
    wb(1, 10'h1BC, 8'hFF);
    poll;
    wb(0, 10'h1BC, 8'h00);
    chk(rd, 8'hA5);
    i_slot <= 5'h1F;
    repeat (3) @(posedge i_clock);
    chk({o_framer_valid, o_framer_pcm, o_framer_idle, o_framer_sig},
      25'h13CC37E);
    wb(1, 10'h1B0, 8'h02);
    repeat (3) @(posedge i_clock);
    chk({o_framer_valid, o_framer_pcm, o_framer_idle, o_framer_sig},
      0);
    wb(0, 10'h3FC, 8'h00);
    chk(rd, 0);
    // reset in the middle of a read access of 3FH
    wb(1, 10'h1B8, 8'hBF);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    chk({o_wb_ack, o_framer_valid}, 0);
    check_defaults;
    wb(1, 10'h1B0, 8'h03);
    acc(8'hBF);
    wb(0, 10'h1BC, 8'h00);
    chk(rd, 0);
    summarize;
  end
endmodule
